// >>> rtl/output_frequency_limiter.sv
`default_nettype none

module output_frequency_limiter
  import freq_limit_pkg::*;
(
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset,
  // setting store port
  input  wire logic             wr_en,
  input  wire logic [ID_W-1:0]  wr_sel,
  input  wire logic [VAL_W-1:0] wr_data,
  output logic                  wr_ack_q,
  output logic                  wr_err_q,
  input  wire logic [ID_W-1:0]  rd_sel,
  output logic [VAL_W-1:0]      rd_data_q,
  // pins
  input  wire logic             start_in,
  input  wire logic             jog_in,
  input  wire logic             second_function_input,
  // command and supply
  input  wire logic [VAL_W-1:0] set_freq,
  input  wire logic [VAL_W-1:0] supply_voltage,
  // results
  output logic [VAL_W-1:0]      target_freq_q,
  output logic                  jump_hold_q,
  output logic [VAL_W-1:0]      eff_base_freq_q,
  output logic [VAL_W-1:0]      eff_base_voltage_q
);

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function automatic logic locked_id(input logic [ID_W-1:0] id);
    locked_id = (id != P_START) && (id != P_JOG) && (id != P_UGROUP);
  endfunction

  function automatic logic in_range(input logic [ID_W-1:0] id,
                                    input logic [VAL_W-1:0] v);
    logic r;
    r = 1'b0;
    if (id == P_UPPER || id == P_LOWER) begin
      r = (v <= FREQ_120);
    end else if (id == P_EXT) begin
      r = (v >= FREQ_120) && (v <= FREQ_400);
    end else if (id == P_START || id == P_JOG || id == P_BASE) begin
      r = (v <= FREQ_400);
    end else if (id >= P_JUMP0 && id < P_BASE) begin
      r = (v <= FREQ_400) || (v == CODE_OFF);
    end else if (id == P_BASE2) begin
      r = (v <= FREQ_400) || (v == CODE_OFF);
    end else if (id == P_BASEV) begin
      r = (v <= VOLT_1000) || (v == CODE_V95) || (v == CODE_OFF);
    end else if (id == P_UGROUP) begin
      r = 1'b1;
    end
    in_range = r;
  endfunction

  // ------------------------------------------------------------
  // setting store
  // ------------------------------------------------------------
  logic [VAL_W-1:0] set_q [NUM_PARAM];

  wire ugroup_open = (set_q[P_UGROUP] == 16'h0000);
  wire id_valid    = (wr_sel < ID_W'(NUM_PARAM));
  wire wr_ok       = wr_en && id_valid && in_range(wr_sel, wr_data)
                     && (ugroup_open || !locked_id(wr_sel));
  wire limit_pair  = (wr_sel == P_UPPER) || (wr_sel == P_EXT);

  // store writes, upper and extended limit share each write
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NUM_PARAM; i++) begin
        set_q[i] <= RESET_VALS[i];
      end
    end else begin
      for (int i = 0; i < NUM_PARAM; i++) begin
        if (wr_ok && (wr_sel == ID_W'(i))) begin
          set_q[i] <= wr_data;
        end
      end
      if (wr_ok && limit_pair) begin
        set_q[P_UPPER] <= wr_data;
        set_q[P_EXT]   <= wr_data;
      end
    end
  end

  // write answer and readback
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wr_ack_q  <= 1'b0;
      wr_err_q  <= 1'b0;
      rd_data_q <= 16'h0000;
    end else begin
      wr_ack_q  <= wr_ok;
      wr_err_q  <= wr_en && !wr_ok;
      rd_data_q <= (rd_sel < ID_W'(NUM_PARAM)) ? set_q[rd_sel] : 16'h0000;
    end
  end

  // named views of the store
  wire [VAL_W-1:0] upper_freq_limit    = set_q[P_UPPER];
  wire [VAL_W-1:0] lower_freq_limit    = set_q[P_LOWER];
  wire [VAL_W-1:0] extended_upper_limit = set_q[P_EXT];
  wire [VAL_W-1:0] starting_freq       = set_q[P_START];
  wire [VAL_W-1:0] jog_freq            = set_q[P_JOG];
  wire [VAL_W-1:0] base_freq           = set_q[P_BASE];
  wire [VAL_W-1:0] base_voltage        = set_q[P_BASEV];
  wire [VAL_W-1:0] second_base_freq    = set_q[P_BASE2];

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;

  // two flops per pin: start, jog, second function
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pin_meta_q <= 3'h0;
      pin_sync_q <= 3'h0;
    end else begin
      pin_meta_q <= {second_function_input, jog_in, start_in};
      pin_sync_q <= pin_meta_q;
    end
  end

  wire start_s  = pin_sync_q[0];
  wire jog_s    = pin_sync_q[1];
  wire second_s = pin_sync_q[2];

  // ------------------------------------------------------------
  // jump bands
  // ------------------------------------------------------------
  logic [NUM_BAND-1:0] band_hit;
  logic [VAL_W-1:0]    band_point [NUM_BAND];

  genvar g;
  generate
    for (g = 0; g < NUM_BAND; g++) begin : g_band
      jump_band u_band (
        .bound_a (set_q[P_JUMP0 + 2*g]),
        .bound_b (set_q[P_JUMP0 + 2*g + 1]),
        .freq    (set_freq),
        .hit     (band_hit[g]),
        .point   (band_point[g])
      );
    end
  endgenerate

  // lowest numbered band wins
  wire [VAL_W-1:0] jumped = band_hit[0] ? band_point[0] :
                            band_hit[1] ? band_point[1] :
                            band_hit[2] ? band_point[2] : set_freq;

  // ------------------------------------------------------------
  // clamps, jump applied before them
  // ------------------------------------------------------------
  wire [VAL_W-1:0] ceiling = extended_upper_limit;
  wire [VAL_W-1:0] capped  = (jumped > ceiling) ? ceiling : jumped;
  wire [VAL_W-1:0] floored = (capped < lower_freq_limit)
                             ? lower_freq_limit : capped;
  wire [VAL_W-1:0] jog_cap = (jog_freq > ceiling) ? ceiling : jog_freq;
  wire [VAL_W-1:0] run_val = jog_s ? jog_cap : floored;
  wire [VAL_W-1:0] target_d = start_s ? run_val : FREQ_0;
  wire             hold_d   = start_s && !jog_s && (|band_hit);

  // steady target only; the ramp downstream crosses bands freely
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      target_freq_q <= 16'h0000;
      jump_hold_q   <= 1'b0;
    end else begin
      target_freq_q <= target_d;
      jump_hold_q   <= hold_d;
    end
  end

  // ------------------------------------------------------------
  // base frequency and voltage for the v/f stage
  // ------------------------------------------------------------
  logic [31:0] v95_wide;
  assign v95_wide = (32'(supply_voltage) * 32'(PCT_NUM)) / 32'(PCT_DEN);

  wire             use_second = second_s && (second_base_freq != CODE_OFF);
  wire [VAL_W-1:0] base_f_d   = use_second ? second_base_freq : base_freq;
  wire [VAL_W-1:0] volt_req   = (base_voltage == CODE_V95) ? v95_wide[VAL_W-1:0] :
                                (base_voltage == CODE_OFF) ? supply_voltage :
                                base_voltage;
  wire [VAL_W-1:0] volt_d     = (volt_req > supply_voltage)
                                ? supply_voltage : volt_req;

  // v/f settings registered
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      eff_base_freq_q    <= 16'h0000;
      eff_base_voltage_q <= 16'h0000;
    end else begin
      eff_base_freq_q    <= base_f_d;
      eff_base_voltage_q <= volt_d;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_upper_cap;
    @(posedge ref_clk) disable iff (reset)
    start_s |=> (target_freq_q <= $past(extended_upper_limit));
  endproperty
  a_upper_cap: assert property (p_upper_cap)
    else $error("target above upper limit");

  property p_lower_hold;
    @(posedge ref_clk) disable iff (reset)
    (start_s && !jog_s && lower_freq_limit <= ceiling)
      |=> (target_freq_q >= $past(lower_freq_limit));
  endproperty
  a_lower_hold: assert property (p_lower_hold)
    else $error("target below lower limit");

  property p_mirror;
    @(posedge ref_clk) disable iff (reset)
    (wr_ok && limit_pair)
      |=> (upper_freq_limit == extended_upper_limit)
          && (upper_freq_limit == $past(wr_data));
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("limits not mirrored");

  property p_jog_first;
    @(posedge ref_clk) disable iff (reset)
    (start_s && jog_s && jog_freq <= lower_freq_limit && jog_freq <= ceiling)
      |=> (target_freq_q == $past(jog_freq));
  endproperty
  a_jog_first: assert property (p_jog_first)
    else $error("jog not taken over lower limit");

  property p_start_lower;
    @(posedge ref_clk) disable iff (reset)
    (start_s && !jog_s && set_freq == FREQ_0 && band_hit == 3'h0
     && lower_freq_limit > starting_freq && lower_freq_limit <= ceiling)
      |=> (target_freq_q == $past(lower_freq_limit));
  endproperty
  a_start_lower: assert property (p_start_lower)
    else $error("start alone not at lower limit");

  property p_jump_point;
    @(posedge ref_clk) disable iff (reset)
    (start_s && !jog_s && band_hit[0] && band_point[0] <= ceiling
     && band_point[0] >= lower_freq_limit)
      |=> (target_freq_q == $past(band_point[0])) && jump_hold_q;
  endproperty
  a_jump_point: assert property (p_jump_point)
    else $error("band 1 not held at its A setting");

  property p_second_band;
    @(posedge ref_clk) disable iff (reset)
    (start_s && !jog_s && !band_hit[0] && band_hit[1] && band_point[1] <= ceiling
     && band_point[1] >= lower_freq_limit)
      |=> (target_freq_q == $past(band_point[1])) && jump_hold_q;
  endproperty
  a_second_band: assert property (p_second_band)
    else $error("band 2 not held at its A setting");

  property p_locked;
    @(posedge ref_clk) disable iff (reset)
    (wr_en && locked_id(wr_sel) && !ugroup_open)
      |=> wr_err_q && !wr_ack_q && $stable(set_q[P_LOWER]);
  endproperty
  a_locked: assert property (p_locked)
    else $error("locked setting accepted");

  property p_second_base;
    @(posedge ref_clk) disable iff (reset)
    (second_s && second_base_freq != CODE_OFF)
      |=> (eff_base_freq_q == $past(second_base_freq));
  endproperty
  a_second_base: assert property (p_second_base)
    else $error("second base frequency not used");

  property p_volt_cap;
    @(posedge ref_clk) disable iff (reset)
    1'b1 |=> (eff_base_voltage_q <= $past(supply_voltage));
  endproperty
  a_volt_cap: assert property (p_volt_cap)
    else $error("base voltage above supply");

  property p_volt_full;
    @(posedge ref_clk) disable iff (reset)
    (base_voltage == CODE_OFF) |=> (eff_base_voltage_q == $past(supply_voltage));
  endproperty
  a_volt_full: assert property (p_volt_full)
    else $error("code 9999 not at supply voltage");

  property p_stopped;
    @(posedge ref_clk) disable iff (reset)
    !start_s |=> (target_freq_q == FREQ_0) && !jump_hold_q;
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("target nonzero without start");

endmodule

`default_nettype wire

// >>> rtl/freq_limit_pkg.sv
// Behaviour
// - clamp output at upper limit, default 120Hz; a lower limit set above it wins
// - extended upper limit 120-400Hz sets ceiling
// - upper and extended limit writes mirror each other
// - hold output at lower limit, 0-120Hz
// - jog at or below lower skips lower clamp, still capped at ceiling
// - start alone runs up to lower limit
// - three jump bands, 0-400Hz, 9999 disables
// - inside enabled band run at A setting
// - pair order chooses band hold edge
// - ramps pass through bands, target only jumps
// - base frequency 0-400Hz, default 50Hz
// - base voltage 0-1000V, 8888=95%, 9999=supply
// - second function selects second base frequency
// - settings other than start, jog and user group writable only when user group 0
// - base voltage caps output, never above supply
`default_nettype none

package freq_limit_pkg;

  // ------------------------------------------------------------
  // units and codes
  // ------------------------------------------------------------
  localparam int          VAL_W      = 16;        // 0.1 Hz or 1 V units
  localparam int          ID_W       = 4;
  localparam int          NUM_PARAM  = 15;
  localparam int          NUM_BAND   = 3;
  localparam logic [15:0] CODE_OFF   = 16'h270F;  // 9999
  localparam logic [15:0] CODE_V95   = 16'h22B8;  // 8888
  localparam logic [15:0] FREQ_0     = 16'h0000;
  localparam logic [15:0] FREQ_120   = 16'h04B0;  // 120.0 Hz
  localparam logic [15:0] FREQ_400   = 16'h0FA0;  // 400.0 Hz
  localparam logic [15:0] VOLT_1000  = 16'h03E8;
  localparam int          PCT_NUM    = 95;
  localparam int          PCT_DEN    = 100;

  // ------------------------------------------------------------
  // setting identifiers
  // ------------------------------------------------------------
  localparam logic [3:0] P_UPPER  = 4'h0;
  localparam logic [3:0] P_LOWER  = 4'h1;
  localparam logic [3:0] P_EXT    = 4'h2;
  localparam logic [3:0] P_START  = 4'h3;
  localparam logic [3:0] P_JOG    = 4'h4;
  localparam logic [3:0] P_JUMP0  = 4'h5;  // 1A,1B,2A,2B,3A,3B follow
  localparam logic [3:0] P_BASE   = 4'hB;
  localparam logic [3:0] P_BASEV  = 4'hC;
  localparam logic [3:0] P_BASE2  = 4'hD;
  localparam logic [3:0] P_UGROUP = 4'hE;

  // ------------------------------------------------------------
  // reset values, indexed by identifier
  // ------------------------------------------------------------
  localparam logic [15:0] RESET_VALS [NUM_PARAM] = '{
    16'h04B0, 16'h0000, 16'h04B0, 16'h0005, 16'h0032,
    16'h270F, 16'h270F, 16'h270F, 16'h270F, 16'h270F, 16'h270F,
    16'h01F4, 16'h22B8, 16'h270F, 16'h0000
  };

endpackage

`default_nettype wire

// >>> rtl/jump_band.sv
`default_nettype none

module jump_band
  import freq_limit_pkg::*;
(
  // band settings
  input  wire logic [VAL_W-1:0] bound_a,
  input  wire logic [VAL_W-1:0] bound_b,
  // frequency under test
  input  wire logic [VAL_W-1:0] freq,
  // result
  output logic                  hit,
  output logic [VAL_W-1:0]      point
);

  // ------------------------------------------------------------
  // inclusive range in either order, off when a bound is 9999
  // ------------------------------------------------------------
  wire             band_on = (bound_a != CODE_OFF) && (bound_b != CODE_OFF);
  wire [VAL_W-1:0] lo      = (bound_a < bound_b) ? bound_a : bound_b;
  wire [VAL_W-1:0] hi      = (bound_a < bound_b) ? bound_b : bound_a;

  assign hit   = band_on && (freq >= lo) && (freq <= hi);
  assign point = bound_a;  // held edge set by pair order

endmodule

`default_nettype wire

// >>> dv/freq_cmd_source.sv
`default_nettype none

module freq_cmd_source
  import freq_limit_pkg::*;
(
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset,
  // requests from the bench
  input  wire logic [VAL_W-1:0] cmd_freq,
  input  wire logic [VAL_W-1:0] cmd_supply,
  input  wire logic [3:0]       term_code,
  input  wire logic             term_raw,
  // toward the limiter
  output logic [VAL_W-1:0]      set_freq,
  output logic [VAL_W-1:0]      supply_voltage,
  output logic                  second_function_input
);
  timeunit 1ns;
  timeprecision 1ns;

  // ------------------------------------------------------------
  // command source and terminal map
  // ------------------------------------------------------------
  // command arrives already gain scaled; terminal passes only when mapped
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      set_freq              <= 16'h0000;
      supply_voltage        <= 16'h0000;
      second_function_input <= 1'b0;
    end else begin
      set_freq              <= cmd_freq;
      supply_voltage        <= cmd_supply;
      second_function_input <= term_raw & (term_code == 4'h3);
    end
  end
endmodule

`default_nettype wire

// >>> dv/testbench.sv
`default_nettype none

`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end

module testbench
  import freq_limit_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic             ref_clk, reset, wr_en, wr_ack_q, wr_err_q, start_in, jog_in;
  logic             jump_hold_q, sfi, term_raw;
  logic [ID_W-1:0]  wr_sel, rd_sel;
  logic [3:0]       term_code;
  logic [VAL_W-1:0] wr_data, rd_data_q, set_freq, supply_voltage, cmd_freq, cmd_supply;
  logic [VAL_W-1:0] target_freq_q, eff_base_freq_q, eff_base_voltage_q;
  int               failures, cmp_count, cycles;

  // clock and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      test_done();
    end
  end

  freq_cmd_source u_src (.ref_clk(ref_clk), .reset(reset), .cmd_freq(cmd_freq),
    .cmd_supply(cmd_supply), .term_code(term_code), .term_raw(term_raw),
    .set_freq(set_freq), .supply_voltage(supply_voltage), .second_function_input(sfi));

  output_frequency_limiter u_dut (.ref_clk(ref_clk), .reset(reset), .wr_en(wr_en),
    .wr_sel(wr_sel), .wr_data(wr_data), .wr_ack_q(wr_ack_q), .wr_err_q(wr_err_q),
    .rd_sel(rd_sel), .rd_data_q(rd_data_q), .start_in(start_in), .jog_in(jog_in),
    .second_function_input(sfi), .set_freq(set_freq), .supply_voltage(supply_voltage),
    .target_freq_q(target_freq_q), .jump_hold_q(jump_hold_q),
    .eff_base_freq_q(eff_base_freq_q), .eff_base_voltage_q(eff_base_voltage_q));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic test_done();
    if (failures == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // one write, judged by ack or refusal
  task automatic wr(input logic [3:0] id, input logic [15:0] v, input logic e);
    @(posedge ref_clk);
    wr_en   <= 1'b1;
    wr_sel  <= id;
    wr_data <= v;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    #1;
    `CHK(wr_err_q, e)
    `CHK(wr_ack_q, ~e)
  endtask

  task automatic ck_r(input logic [3:0] id, input logic [15:0] e);
    @(posedge ref_clk);
    rd_sel <= id;
    @(posedge ref_clk);
    #1;
    `CHK(rd_data_q, e)
  endtask

  task automatic settle();
    repeat (5) @(posedge ref_clk);
    #1;
  endtask

  // apply a command and judge the target
  task automatic ck_f(input logic [15:0] f, input logic [15:0] e);
    @(posedge ref_clk);
    cmd_freq <= f;
    settle();
    `CHK(target_freq_q, e)
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic s_defaults();
    for (int i = 0; i < NUM_PARAM; i++) ck_r(i[3:0], RESET_VALS[i]);
    `CHK(eff_base_freq_q, 16'h01F4)
    `CHK(eff_base_voltage_q, 16'h017C)
  endtask

  task automatic s_upper();
    @(posedge ref_clk);
    start_in <= 1'b1;
    ck_f(16'h05DC, 16'h04B0);
    wr(P_EXT, 16'h07D0, 1'b0);
    ck_r(P_UPPER, 16'h07D0);
    ck_f(16'h09C4, 16'h07D0);
    wr(P_EXT, 16'h03E8, 1'b1);
    wr(P_UPPER, 16'h03E8, 1'b0);
    ck_r(P_EXT, 16'h03E8);
    wr(P_UPPER, 16'h04B1, 1'b1);
  endtask

  task automatic s_lower();
    wr(P_LOWER, 16'h0064, 1'b0);
    ck_f(16'h0032, 16'h0064);
    ck_f(16'h0000, 16'h0064);
    wr(P_JOG, 16'h0050, 1'b0);
    @(posedge ref_clk);
    jog_in <= 1'b1;
    ck_f(16'h0000, 16'h0050);
    @(posedge ref_clk);
    jog_in <= 1'b0;
  endtask

  task automatic s_jump();
    wr(P_JUMP0, 16'h012C, 1'b0);
    wr(P_JUMP0 + 4'h1, 16'h00C8, 1'b0);
    ck_f(16'h00C8, 16'h012C);
    `CHK(jump_hold_q, 1'b1)
    wr(P_JUMP0 + 4'h2, 16'h0190, 1'b0);
    wr(P_JUMP0 + 4'h3, 16'h01F4, 1'b0);
    ck_f(16'h01C2, 16'h0190);
    wr(P_JUMP0 + 4'h4, CODE_OFF, 1'b0);
    wr(P_JUMP0 + 4'h5, 16'h02BC, 1'b0);
    ck_f(16'h028A, 16'h028A);
    `CHK(jump_hold_q, 1'b0)
    wr(P_JUMP0 + 4'h4, 16'h003C, 1'b0);
    wr(P_JUMP0 + 4'h5, 16'h005A, 1'b0);
    ck_f(16'h0046, 16'h0064);
    wr(P_JUMP0 + 4'h1, 16'h01C2, 1'b0);
    ck_f(16'h01A4, 16'h012C);
    wr(P_JUMP0, 16'h0FA1, 1'b1);
  endtask

  task automatic s_base();
    wr(P_BASE2, 16'h0258, 1'b0);
    @(posedge ref_clk);
    term_raw <= 1'b1;
    settle();
    `CHK(eff_base_freq_q, 16'h0258)
    @(posedge ref_clk);
    term_code <= 4'h0;
    settle();
    `CHK(eff_base_freq_q, 16'h01F4)
    wr(P_BASE, 16'h0FA1, 1'b1);
    wr(P_BASE, 16'h01C2, 1'b0);
    settle();
    `CHK(eff_base_freq_q, 16'h01C2)
    wr(P_BASEV, CODE_OFF, 1'b0);
    settle();
    `CHK(eff_base_voltage_q, 16'h0190)
    wr(P_BASEV, 16'h012C, 1'b0);
    settle();
    `CHK(eff_base_voltage_q, 16'h012C)
    wr(P_BASEV, VOLT_1000, 1'b0);
    settle();
    `CHK(eff_base_voltage_q, 16'h0190)
    wr(P_BASEV, 16'h03E9, 1'b1);
    wr(P_BASE2, CODE_OFF, 1'b0);
    @(posedge ref_clk);
    term_code <= 4'h3;
    settle();
    `CHK(eff_base_freq_q, 16'h01C2)
  endtask

  task automatic s_lock();
    wr(P_UGROUP, 16'h0001, 1'b0);
    wr(P_UPPER, 16'h01F4, 1'b1);
    wr(P_JUMP0, 16'h0064, 1'b1);
    wr(P_JOG, 16'h003C, 1'b0);
    ck_r(P_UPPER, 16'h03E8);
    wr(P_UGROUP, 16'h0000, 1'b0);
    wr(4'hF, 16'h0000, 1'b1);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    reset = 1'b1;
    {wr_en, start_in, jog_in, term_raw} = 4'h0;
    wr_sel     = 4'h0;
    rd_sel     = 4'h0;
    wr_data    = 16'h0000;
    term_code  = 4'h3;
    cmd_freq   = 16'h0000;
    cmd_supply = 16'h0190;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    settle();
    s_defaults();
    s_upper();
    s_lower();
    s_jump();
    s_base();
    s_lock();
    test_done();
  end
endmodule

`default_nettype wire
